//--- rtl/nsx_exec.v
// decode and execute for nibble swap, xor literal, xor file and direction load
`timescale 1ns/1ns
`include "nsx_regs.vh"

module nsx_exec
(
    clock,
    rstn,
    instr_valid,
    instr,
    w_reg,
    zero_flag,
    port_dir,
    file_wr_en,
    file_wr_addr,
    file_wr_data,
    done
);
    input  wire                    clock;
    input  wire                    rstn;
    input  wire                    instr_valid;
    input  wire [`NSX_OPC_W-1:0]   instr;
    output reg  [7:0]              w_reg;
    output reg                     zero_flag;
    output reg  [7:0]              port_dir;
    output reg                     file_wr_en;
    output reg  [4:0]              file_wr_addr;
    output reg  [7:0]              file_wr_data;
    output reg                     done;

    // ----------------------------------------------------------------
    // file register storage
    // ----------------------------------------------------------------
    // kept inside the block; the registered write port only mirrors updates
    reg  [7:0] file_mem [0:`NSX_FILE_DEPTH-1];

    // ----------------------------------------------------------------
    // instruction fields
    // ----------------------------------------------------------------
    wire [4:0] addr     = instr[`NSX_ADDR_MSB:0];
    wire       dest     = instr[`NSX_DEST_BIT];
    wire [7:0] lit      = instr[`NSX_LIT_MSB:0];
    wire [5:0] top      = instr[`NSX_TOP_MSB:`NSX_TOP_LSB];
    wire [3:0] top_nib  = instr[`NSX_TOP_MSB:`NSX_LIT_MSB+1];
    wire [8:0] dirld_hi = instr[`NSX_TOP_MSB:`NSX_PORT_MSB+1];
    wire [2:0] port_sel = instr[`NSX_PORT_MSB:0];

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    reg        nibble_swap_op;
    reg        xor_file_op;
    reg        xor_literal_op;
    reg        port_direction_load_op;

    // encodings outside the four handled here fall through as no-ops
    always @*
    begin
        nibble_swap_op         = 1'b0;
        xor_file_op            = 1'b0;
        xor_literal_op         = 1'b0;
        port_direction_load_op = 1'b0;
        if (instr_valid)
        begin
            if (top == `NSX_TOP_SWAP)
            begin
                nibble_swap_op = 1'b1;
            end
            if (top == `NSX_TOP_XORF)
            begin
                xor_file_op = 1'b1;
            end
            if (top_nib == `NSX_XORL_TOP)
            begin
                xor_literal_op = 1'b1;
            end
            // only select 6 names a direction register; other selects do nothing
            if ((dirld_hi == `NSX_DIRLD_HI) && (port_sel == `NSX_DIR_PORT_SEL))
            begin
                port_direction_load_op = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // operand read and result unit
    // ----------------------------------------------------------------
    wire [7:0] f_val = file_mem[addr];
    wire [7:0] result;
    wire       result_zero;

    nsx_alu u_alu
    (
        .op_swap (nibble_swap_op),
        .op_xorf (xor_file_op),
        .op_xorl (xor_literal_op),
        .w_val   (w_reg),
        .f_val   (f_val),
        .lit     (lit),
        .result  (result),
        .zero    (result_zero)
    );

    // ----------------------------------------------------------------
    // result routing
    // ----------------------------------------------------------------
    reg        to_file;
    reg        to_w;
    reg        flags_touch;

    always @*
    begin
        to_file     = 1'b0;
        to_w        = 1'b0;
        flags_touch = 1'b0;
        if (nibble_swap_op || xor_file_op)
        begin
            if (dest)
            begin
                to_file = 1'b1;
            end
            else
            begin
                to_w = 1'b1;
            end
        end
        if (xor_literal_op)
        begin
            to_w = 1'b1;
        end
        // a swap leaves the zero flag alone, unlike the two xor forms
        if (xor_file_op || xor_literal_op)
        begin
            flags_touch = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // next register values
    // ----------------------------------------------------------------
    reg  [7:0] next_w_reg;
    reg        next_zero_flag;
    reg  [7:0] next_port_dir;
    reg        next_file_wr_en;
    reg  [4:0] next_file_wr_addr;
    reg  [7:0] next_file_wr_data;
    reg        next_done;

    always @*
    begin
        next_w_reg        = w_reg;
        next_zero_flag    = zero_flag;
        next_port_dir     = port_dir;
        next_file_wr_en   = to_file;
        next_file_wr_addr = addr;
        next_file_wr_data = result;
        next_done         = instr_valid;
        if (to_w)
        begin
            next_w_reg = result;
        end
        if (flags_touch)
        begin
            next_zero_flag = result_zero;
        end
        if (port_direction_load_op)
        begin
            next_port_dir = w_reg;
        end
    end

    // ----------------------------------------------------------------
    // file register write, same edge as the working register
    // ----------------------------------------------------------------
    integer i;

    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            for (i = 0; i < `NSX_FILE_DEPTH; i = i + 1)
            begin
                file_mem[i] <= `NSX_FILE_RESET;
            end
        end
        else if (to_file)
        begin
            file_mem[addr] <= result;
        end
    end

    // ----------------------------------------------------------------
    // working register and zero flag
    // ----------------------------------------------------------------
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            w_reg     <= `NSX_W_RESET;
            zero_flag <= 1'b0;
        end
        else
        begin
            w_reg     <= next_w_reg;
            zero_flag <= next_zero_flag;
        end
    end

    // ----------------------------------------------------------------
    // port direction register
    // ----------------------------------------------------------------
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            port_dir <= `NSX_DIR_RESET;
        end
        else
        begin
            port_dir <= next_port_dir;
        end
    end

    // ----------------------------------------------------------------
    // write port mirror, a pulse per file register update
    // ----------------------------------------------------------------
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            file_wr_en   <= 1'b0;
            file_wr_addr <= 5'h00;
            file_wr_data <= 8'h00;
        end
        else
        begin
            file_wr_en   <= next_file_wr_en;
            file_wr_addr <= next_file_wr_addr;
            file_wr_data <= next_file_wr_data;
        end
    end

    // ----------------------------------------------------------------
    // completion pulse, one cycle per accepted instruction
    // ----------------------------------------------------------------
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            done <= 1'b0;
        end
        else
        begin
            done <= next_done;
        end
    end
endmodule

//--- rtl/nsx_regs.vh
// opcode fields, encodings and reset values for the nibble swap / xor / direction-load executor
`ifndef NSX_REGS_VH
`define NSX_REGS_VH

// ----------------------------------------------------------------
// opcode fields
// ----------------------------------------------------------------
`define NSX_OPC_W          12
`define NSX_ADDR_MSB       4
`define NSX_DEST_BIT       5
`define NSX_LIT_MSB        7
`define NSX_TOP_MSB        11
`define NSX_TOP_LSB        6
`define NSX_PORT_MSB       2

// ----------------------------------------------------------------
// encodings
// ----------------------------------------------------------------
`define NSX_TOP_SWAP       6'h0e
`define NSX_TOP_XORF       6'h06
`define NSX_XORL_TOP       4'hf
`define NSX_DIRLD_HI       9'h000
`define NSX_DIR_PORT_SEL   3'h6

// ----------------------------------------------------------------
// sizes and reset values
// ----------------------------------------------------------------
`define NSX_FILE_DEPTH     32
`define NSX_W_RESET        8'h00
`define NSX_DIR_RESET      8'hff
`define NSX_FILE_RESET     8'h00

`endif

//--- rtl/nsx_alu.v
// combinational result unit for the swap and the two xor instructions
`timescale 1ns/1ns
module nsx_alu
(
    op_swap,
    op_xorf,
    op_xorl,
    w_val,
    f_val,
    lit,
    result,
    zero
);
    input  wire       op_swap;
    input  wire       op_xorf;
    input  wire       op_xorl;
    input  wire [7:0] w_val;
    input  wire [7:0] f_val;
    input  wire [7:0] lit;
    output reg  [7:0] result;
    output wire       zero;

    always @*
    begin
        result = 8'h00;
        if (op_swap)
            result = {f_val[3:0], f_val[7:4]};
        else if (op_xorf)
            result = w_val ^ f_val;
        else if (op_xorl)
            result = w_val ^ lit;
    end

    assign zero = (result == 8'h00);
endmodule

//--- verification/nsx_checker.sv
// port assertions for the nibble swap / xor / direction-load executor
`timescale 1ns/1ns
module nsx_checker
(
    input wire        clock,
    input wire        rstn,
    input wire        instr_valid,
    input wire [11:0] instr,
    input wire [7:0]  w_reg,
    input wire        zero_flag,
    input wire [7:0]  port_dir,
    input wire        file_wr_en,
    input wire [4:0]  file_wr_addr,
    input wire [7:0]  file_wr_data,
    input wire        done
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rstn);
    wire xl = instr_valid && instr[11:8] == 4'hf;
    wire xf = instr_valid && instr[11:6] == 6'h06;
    wire sw = instr_valid && instr[11:6] == 6'h0e;
    wire dl = instr_valid && instr[11:3] == 9'h000;
    done_pulse_a: assert property (instr_valid |=> done) else $error("done missing");
    idle_quiet_a: assert property (!instr_valid |=> !done && !file_wr_en) else $error("idle activity");
    lit_xor_a: assert property (xl |=> w_reg == ($past(w_reg) ^ $past(instr[7:0])) && zero_flag == !w_reg)
        else $error("literal xor");
    xor_to_w_a: assert property (xf && !instr[5] |=> !file_wr_en && zero_flag == !w_reg)
        else $error("xor into working");
    xor_to_file_a: assert property (xf && instr[5] |=> file_wr_en && $stable(w_reg) && zero_flag == !file_wr_data)
        else $error("xor into file");
    swap_flags_a: assert property (sw |=> $stable(zero_flag) && file_wr_en == $past(instr[5]))
        else $error("swap flags or route");
    write_addr_a: assert property ((sw || xf) && instr[5] |=> file_wr_addr == $past(instr[4:0]))
        else $error("write address");
    dir_load_a: assert property (dl && instr[2:0] == 3'h6 |=> port_dir == $past(w_reg) && $stable(zero_flag))
        else $error("direction load");
    dir_keep_a: assert property (dl && instr[2:0] != 3'h6 |=> $stable(port_dir)) else $error("direction changed");
endmodule

bind nsx_exec nsx_checker i_nsx_checker (.clock, .rstn, .instr_valid, .instr, .w_reg, .zero_flag, .port_dir,
    .file_wr_en, .file_wr_addr, .file_wr_data, .done);

//--- verification/tb_top.sv
// directed and random instruction stream checked against a bench model
`timescale 1ns/1ns
module tb_top;
    reg         clock = 0, rstn = 0, instr_valid = 0, v, ez = 0, ev = 0, ee = 0;
    reg  [11:0] instr = 0, op;
    reg  [7:0]  mf [0:31];
    reg  [7:0]  ew = 0, ed = 8'hff, r, eq;
    reg  [31:0] rnd;
    reg  [4:0]  ea;
    wire [7:0]  w_reg, port_dir, file_wr_data;
    wire [4:0]  file_wr_addr;
    wire        zero_flag, file_wr_en, done;
    integer     errors = 0, comparisons = 0, i;
    localparam [83:0] seq = {12'hfb5, 12'hfb5, 12'hfb5, 12'hfaf, 12'h1bf, 12'h39f, 12'h006};
    nsx_exec i_nsx_exec (.clock, .rstn, .instr_valid, .instr, .w_reg, .zero_flag, .port_dir, .file_wr_en,
        .file_wr_addr, .file_wr_data, .done);
    initial forever #10 clock = ~clock;
    task chk(input [15:0] got, input [15:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp)
            begin
                errors = errors + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // bit 9 splits swap (set) from file xor (clear)
    function [7:0] exp_res(input [11:0] o, input [7:0] f, input [7:0] w);
        exp_res = o[9] ? {f[3:0], f[7:4]} : f ^ w;
    endfunction
    // model update
    task step(input [11:0] o, input vv);
        begin
            ev = vv;
            ee = 0;
            if (vv && (o[11:6] == 6'h0e || o[11:6] == 6'h06))
            begin
                r = exp_res(o, mf[o[4:0]], ew);
                if (!o[9]) ez = r == 0;
                ee = o[5];
                ea = o[4:0];
                eq = r;
                if (o[5]) mf[o[4:0]] = r;
                else ew = r;
            end
            if (vv && o[11:8] == 4'hf) ew = ew ^ o[7:0];
            if (vv && o[11:8] == 4'hf) ez = ew == 0;
            if (vv && o == 12'h006) ed = ew;
        end
    endtask
    task finish_test;
        begin
            $display("errors %0d comparisons %0d", errors, comparisons);
            if (errors == 0 && comparisons > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial
    begin
        i = $urandom(32'h51ea);
        for (i = 0; i < 32; i = i + 1) mf[i] = 0;
        repeat (20) @(posedge clock);
        rstn <= 1;
        for (i = 0; i < 600; i = i + 1)
        begin
            rnd = $urandom;
            op = rnd[11:0];
            // the last slot is idle so the final instruction is still checked
            v = (i < 7 || $urandom % 5 != 0) && i != 599;
            case ($urandom % 7)
                0, 1: op[11:6] = 6'h0e;
                2, 3: op[11:6] = 6'h06;
                4: op[11:8] = 4'hf;
                5: op[11:3] = 9'h000;
                default: ;
            endcase
            if (i < 7) op = seq[83 - 12 * i -: 12];
            @(posedge clock);
            instr <= op;
            instr_valid <= v;
            @(negedge clock);
            chk(done, ev);
            chk(w_reg, ew);
            chk(zero_flag, ez);
            chk(port_dir, ed);
            chk(file_wr_en, ee);
            if (ee) chk({file_wr_addr, file_wr_data}, {ea, eq});
            step(op, v);
        end
        finish_test;
    end
endmodule
